// >>> phy_mgmt_register_bank.sv
// Management register bank of a 10/100 transceiver
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_register_bank
    import phy_mgmt_pkg::*;
(
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // Management port
    input  wire logic [ADDR_W-1:0]  addr_i,
    input  wire logic [DATA_W-1:0]  wdata_i,
    input  wire logic               wr_i,
    input  wire logic               rd_i,
    output logic      [DATA_W-1:0]  rdata_o,
    // Line events and status
    input  wire logic               false_carrier_i,
    input  wire logic               receive_error_i,
    input  wire line_status_t       status_i,
    // Strap pins
    input  wire logic [STRAP_W-1:0] strap_i,
    // Control outputs
    output logic                    soft_reset_o,
    output logic                    loopback_o,
    output logic      [DATA_W-1:0]  pcs_cfg_o,
    output logic      [DATA_W-1:0]  phy_ctrl_o,
    output logic      [DATA_W-1:0]  slow_link_o,
    output logic      [DATA_W-1:0]  line_test_o,
    // Interrupt
    output logic                    irq_o
);
    localparam int RST_LO = SW_RESET_CYCLES;
    localparam int RST_HI = SW_RESET_CYCLES + 1;

    logic [5:0]         rst_cnt;
    logic               reset_done;
    logic               wr_ok;
    logic               strap_load;
    logic               load_after_rst;
    logic [STRAP_W-1:0] strap_meta;
    logic [STRAP_W-1:0] strap_q;
    logic [DATA_W-1:0]  next_phy_ctrl;
    logic [DATA_W-1:0]  next_rdata;
    logic [1:0]         cnt_event;
    logic [1:0]         cnt_clear;
    logic [CNT_W-1:0]   cnt_value [2];
    logic               lat_link;
    logic               lat_jab;
    logic               link_q;
    logic               jab_q;
    logic [IRQ_W-1:0]   irq_status;
    logic [IRQ_W-1:0]   irq_mask;
    logic [IRQ_W-1:0]   irq_event;
    logic [IRQ_W-1:0]   irq_w1c;
    logic               rd_latch;

    assign wr_ok      = wr_i && !soft_reset_o;
    assign reset_done = soft_reset_o && rst_cnt == 6'h00;
    assign strap_load = load_after_rst || reset_done;
    assign rd_latch   = rd_i && addr_i == LATCHED_STATUS_OFS;

    // ------------------------------------------------------------
    // Strap synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        strap_meta <= strap_i;
        strap_q    <= strap_meta;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            load_after_rst <= 1'b1;
        end else begin
            load_after_rst <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Software reset sequence
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            soft_reset_o <= 1'b0;
            rst_cnt      <= 6'h00;
        end else if (reset_done) begin
            soft_reset_o <= 1'b0;
        end else if (wr_ok && addr_i == BASIC_MODE_CONTROL_OFS
                     && wdata_i[SOFT_RESET_BIT]) begin
            soft_reset_o <= 1'b1;
            rst_cnt      <= 6'(SW_RESET_CYCLES - 1);
        end else if (soft_reset_o) begin
            rst_cnt <= rst_cnt - 6'h01;
        end
    end

    // ------------------------------------------------------------
    // Plain configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i || reset_done) begin
            loopback_o  <= 1'b0;
            pcs_cfg_o   <= PCS_RESET;
            slow_link_o <= SLOW_LINK_RESET;
            line_test_o <= LINE_TEST_RESET;
        end else if (wr_ok) begin
            case (addr_i)
                BASIC_MODE_CONTROL_OFS: begin
                    loopback_o <= wdata_i[LOOPBACK_BIT];
                end
                CODING_SUBLAYER_CONFIG_OFS: begin
                    pcs_cfg_o <= wdata_i & PCS_WR_MASK;
                end
                SLOW_LINK_STATUS_CONTROL_OFS: begin
                    slow_link_o <= wdata_i & SLOW_LINK_WR_MASK;
                end
                LINE_TEST_CONTROL_OFS: begin
                    line_test_o <= wdata_i & LINE_TEST_WR_MASK;
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // PHY control register
    // ------------------------------------------------------------
    always_comb begin
        next_phy_ctrl = phy_ctrl_o;
        if (strap_load) begin
            next_phy_ctrl = {9'h000, strap_q};
        end else if (wr_ok && addr_i == PHY_CONTROL_OFS) begin
            next_phy_ctrl = (phy_ctrl_o & ~PHY_CTRL_WR_MASK)
                          | (wdata_i & PHY_CTRL_WR_MASK);
        end
        if (status_i.self_test_done) begin
            next_phy_ctrl[SELF_TEST_GO_BIT] = 1'b0;
            next_phy_ctrl[SELF_TEST_OK_BIT] = status_i.self_test_pass;
        end
        next_phy_ctrl[PAUSE_BIT] = status_i.pause;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phy_ctrl_o <= PHY_CTRL_RESET;
        end else begin
            phy_ctrl_o <= next_phy_ctrl;
        end
    end

    // ------------------------------------------------------------
    // Clear-on-read counters
    // ------------------------------------------------------------
    assign cnt_event = {receive_error_i, false_carrier_i};

    generate
        for (genvar i = 0; i < 2; i++) begin : g_cnt
            localparam logic [4:0] OFS = (i == 0) ? FALSE_CARRIER_COUNTER_OFS
                                                  : RECEIVE_ERROR_COUNTER_OFS;
            assign cnt_clear[i] = (rd_i && addr_i == OFS) || reset_done;
            event_counter #(
                .WIDTH (CNT_W)
            ) u_cnt (
                .clk_i   (clk_i),
                .rst_i   (rst_i),
                .clear_i (cnt_clear[i]),
                .event_i (cnt_event[i]),
                .count_o (cnt_value[i])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Latched link and jabber status
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lat_link <= 1'b1;
        end else if (rd_latch) begin
            lat_link <= status_i.link_up;
        end else if (!status_i.link_up) begin
            lat_link <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lat_jab <= 1'b0;
        end else if (rd_latch) begin
            lat_jab <= status_i.jabber;
        end else if (status_i.jabber) begin
            lat_jab <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            link_q <= 1'b1;
            jab_q  <= 1'b0;
        end else begin
            link_q <= status_i.link_up;
            jab_q  <= status_i.jabber;
        end
    end

    assign irq_event = {reset_done, status_i.self_test_done,
                        status_i.jabber && !jab_q, link_q && !status_i.link_up,
                        receive_error_i, false_carrier_i};
    assign irq_w1c   = (wr_i && addr_i == IRQ_STATUS_OFS) ? wdata_i[IRQ_W-1:0]
                                                          : '0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~irq_w1c) | irq_event;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask <= '0;
        end else if (wr_i && addr_i == IRQ_MASK_OFS) begin
            irq_mask <= wdata_i[IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_status & irq_mask);
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = '0;
        case (addr_i)
            BASIC_MODE_CONTROL_OFS: begin
                next_rdata[SOFT_RESET_BIT] = soft_reset_o;
                next_rdata[LOOPBACK_BIT]   = loopback_o;
            end
            FALSE_CARRIER_COUNTER_OFS: begin
                next_rdata = {8'h00, cnt_value[0]};
            end
            RECEIVE_ERROR_COUNTER_OFS: begin
                next_rdata = {8'h00, cnt_value[1]};
            end
            CODING_SUBLAYER_CONFIG_OFS: begin
                next_rdata = pcs_cfg_o;
                next_rdata[PCS_FIXED_BIT] = PCS_FIXED_VALUE;
            end
            PHY_CONTROL_OFS: begin
                next_rdata = phy_ctrl_o;
            end
            SLOW_LINK_STATUS_CONTROL_OFS: begin
                next_rdata = slow_link_o;
                next_rdata[POLARITY_BIT] = status_i.polarity;
            end
            LINE_TEST_CONTROL_OFS: begin
                next_rdata = line_test_o;
            end
            IRQ_STATUS_OFS: begin
                next_rdata = {10'h000, irq_status};
            end
            IRQ_MASK_OFS: begin
                next_rdata = {10'h000, irq_mask};
            end
            LATCHED_STATUS_OFS: begin
                next_rdata = {14'h0000, lat_jab, lat_link};
            end
            default: begin
                next_rdata = '0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= '0;
        end else if (rd_i) begin
            rdata_o <= next_rdata;
        end else begin
            rdata_o <= '0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_reset_start;
        wr_i && !soft_reset_o && addr_i == BASIC_MODE_CONTROL_OFS
            && wdata_i[SOFT_RESET_BIT] |=> soft_reset_o;
    endproperty
    a_reset_start: assert property (p_reset_start)
        else $error("software reset did not start");

    property p_reset_holds;
        $rose(soft_reset_o) |-> soft_reset_o[*8];
    endproperty
    a_reset_holds: assert property (p_reset_holds)
        else $error("reset bit dropped too early");

    property p_reset_clears;
        $rose(soft_reset_o) |-> ##[RST_LO:RST_HI] !soft_reset_o;
    endproperty
    a_reset_clears: assert property (p_reset_clears)
        else $error("reset bit did not self-clear");

    property p_restrap;
        $fell(soft_reset_o) |-> phy_ctrl_o[STRAP_W-1:0] == $past(strap_q);
    endproperty
    a_restrap: assert property (p_restrap)
        else $error("straps not reloaded by software reset");

    property p_loopback;
        wr_ok && addr_i == BASIC_MODE_CONTROL_OFS && !wdata_i[SOFT_RESET_BIT]
            |=> loopback_o == $past(wdata_i[LOOPBACK_BIT]);
    endproperty
    a_loopback: assert property (p_loopback)
        else $error("loopback bit not written");

    property p_pause;
        ##1 phy_ctrl_o[PAUSE_BIT] == $past(status_i.pause);
    endproperty
    a_pause: assert property (p_pause)
        else $error("pause bit does not follow its event");

    property p_self_test_clear;
        status_i.self_test_done |=> !phy_ctrl_o[SELF_TEST_GO_BIT];
    endproperty
    a_self_test_clear: assert property (p_self_test_clear)
        else $error("self-test start did not self-clear");

    property p_clear_on_read;
        rd_i && addr_i == FALSE_CARRIER_COUNTER_OFS && !soft_reset_o
            |=> cnt_value[0] == CNT_W'($past(false_carrier_i));
    endproperty
    a_clear_on_read: assert property (p_clear_on_read)
        else $error("counter not cleared by read");

    property p_fixed_bit;
        rd_i && addr_i == CODING_SUBLAYER_CONFIG_OFS
            |=> rdata_o[PCS_FIXED_BIT] == PCS_FIXED_VALUE;
    endproperty
    a_fixed_bit: assert property (p_fixed_bit)
        else $error("fixed bit changed");

    property p_latched_low;
        !lat_link && !rd_latch |=> !lat_link;
    endproperty
    a_latched_low: assert property (p_latched_low)
        else $error("latched-low bit released without a read");

    property p_latched_high;
        status_i.jabber |=> lat_jab;
    endproperty
    a_latched_high: assert property (p_latched_high)
        else $error("latched-high bit missed its event");

    property p_reserved;
        rd_i && addr_i inside {[5'h01:5'h13], 5'h17, 5'h18, 5'h1f} |=> rdata_o == '0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved offset read nonzero");

    c_soft_reset: cover property ($fell(soft_reset_o));
    c_count_read: cover property (rd_i && addr_i == RECEIVE_ERROR_COUNTER_OFS
                                  && cnt_value[1] != '0);
    c_latch_low: cover property (!lat_link ##1 status_i.link_up ##1 rd_latch);
    c_irq: cover property ($rose(irq_o));
endmodule
`default_nettype wire

// >>> phy_mgmt_pkg.sv
// Constants and types for the transceiver management register bank
package phy_mgmt_pkg;

    localparam int ADDR_W  = 5;
    localparam int DATA_W  = 16;
    localparam int CNT_W   = 8;
    localparam int STRAP_W = 7;
    localparam int IRQ_W   = 6;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [4:0] BASIC_MODE_CONTROL_OFS       = 5'h00;
    localparam logic [4:0] FALSE_CARRIER_COUNTER_OFS    = 5'h14;
    localparam logic [4:0] RECEIVE_ERROR_COUNTER_OFS    = 5'h15;
    localparam logic [4:0] CODING_SUBLAYER_CONFIG_OFS   = 5'h16;
    localparam logic [4:0] PHY_CONTROL_OFS              = 5'h19;
    localparam logic [4:0] SLOW_LINK_STATUS_CONTROL_OFS = 5'h1a;
    localparam logic [4:0] LINE_TEST_CONTROL_OFS        = 5'h1b;
    localparam logic [4:0] IRQ_STATUS_OFS               = 5'h1c;
    localparam logic [4:0] IRQ_MASK_OFS                 = 5'h1d;
    localparam logic [4:0] LATCHED_STATUS_OFS           = 5'h1e;

    // ------------------------------------------------------------
    // Field positions and masks
    // ------------------------------------------------------------
    localparam int SOFT_RESET_BIT   = 15;
    localparam int LOOPBACK_BIT     = 14;
    localparam int PAUSE_BIT        = 7;
    localparam int SELF_TEST_GO_BIT = 9;
    localparam int SELF_TEST_OK_BIT = 10;
    localparam int POLARITY_BIT     = 4;
    localparam int PCS_FIXED_BIT    = 7;
    localparam logic PCS_FIXED_VALUE = 1'b0;
    localparam logic [15:0] PCS_WR_MASK       = 16'h1f27;
    localparam logic [15:0] PHY_CTRL_WR_MASK  = 16'h0b7f;
    localparam logic [15:0] SLOW_LINK_WR_MASK = 16'h01c3;
    localparam logic [15:0] LINE_TEST_WR_MASK = 16'hff1f;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] PCS_RESET       = 16'h0000;
    localparam logic [15:0] PHY_CTRL_RESET  = 16'h0000;
    localparam logic [15:0] SLOW_LINK_RESET = 16'h0000;
    localparam logic [15:0] LINE_TEST_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS     = 20;
    localparam int SW_RESET_TIME_NS  = 1000;
    localparam int SW_RESET_CYCLES   =
        (SW_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Line status from the datapath
    typedef struct packed {
        logic link_up;
        logic jabber;
        logic pause;
        logic polarity;
        logic self_test_done;
        logic self_test_pass;
    } line_status_t;
endpackage

// >>> event_counter.sv
// Saturating event counter cleared by a read
`timescale 1ns/1ps
`default_nettype none
module event_counter
    import phy_mgmt_pkg::*;
#(
    parameter int WIDTH = CNT_W
)(
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Control
    input  wire logic             clear_i,
    input  wire logic             event_i,
    // Count
    output logic      [WIDTH-1:0] count_o
);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_o <= '0;
        end else if (clear_i) begin
            count_o <= {{(WIDTH-1){1'b0}}, event_i};
        end else if (event_i && count_o != {WIDTH{1'b1}}) begin
            count_o <= count_o + 1'b1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_count_step;
        !clear_i && event_i && count_o != {WIDTH{1'b1}} |=> count_o == $past(count_o) + 1'b1;
    endproperty
    a_count_step: assert property (p_count_step) else $error("counter missed an event");
endmodule
`default_nettype wire

// >>> line_side_model.sv
// Line side model: events, status, straps and self-test responder
`timescale 1ns/1ps
`default_nettype none
module line_side_model
    import phy_mgmt_pkg::*;
#(
    parameter int DONE_DELAY = 4
)(
    // Clock
    input  wire logic               clk_i,
    // Control image from the bank
    input  wire logic [DATA_W-1:0]  phy_ctrl_i,
    // Line side
    output var logic                false_carrier_o,
    output var logic                receive_error_o,
    output var line_status_t        status_o,
    output var logic [STRAP_W-1:0]  strap_o
);
    int   wait_cnt = 0;
    logic go_q     = 1'b0;

    initial begin
        false_carrier_o  = 1'b0;
        receive_error_o  = 1'b0;
        status_o         = '0;
        status_o.link_up = 1'b1;
        strap_o          = 7'h5a;
    end

    // Hold one event or condition for n edges
    task automatic blip(input int which, input int n);
        @(posedge clk_i);
        case (which)
            0: false_carrier_o <= 1'b1;
            1: receive_error_o <= 1'b1;
            2: status_o.link_up <= 1'b0;
            default: status_o.jabber <= 1'b1;
        endcase
        repeat (n) @(posedge clk_i);
        false_carrier_o  <= 1'b0;
        receive_error_o  <= 1'b0;
        status_o.link_up <= 1'b1;
        status_o.jabber  <= 1'b0;
    endtask

    task automatic set_line(input logic pause, input logic polarity);
        status_o.pause    <= pause;
        status_o.polarity <= polarity;
    endtask

    task automatic set_strap(input logic [STRAP_W-1:0] v);
        strap_o <= v;
    endtask

    // Self-test answers a start after a delay
    always @(posedge clk_i) begin
        go_q <= phy_ctrl_i[SELF_TEST_GO_BIT];
        status_o.self_test_done <= 1'b0;
        if (phy_ctrl_i[SELF_TEST_GO_BIT] && !go_q) begin
            wait_cnt <= DONE_DELAY;
        end else if (wait_cnt > 1) begin
            wait_cnt <= wait_cnt - 1;
        end else if (wait_cnt == 1) begin
            wait_cnt <= 0;
            status_o.self_test_done <= 1'b1;
            status_o.self_test_pass <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// >>> phy_mgmt_register_bank_tb.sv
// Self-checking bench for the management register bank
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_register_bank_tb
    import phy_mgmt_pkg::*;
;
    typedef struct packed {
        logic [4:0]  ofs;
        logic [15:0] wval;
        logic [15:0] rval;
    } row_t;

    logic               clk   = 1'b0;
    logic               rst   = 1'b1;
    logic [ADDR_W-1:0]  addr  = '0;
    logic [DATA_W-1:0]  wdata = '0;
    logic               wr    = 1'b0;
    logic               rd    = 1'b0;
    logic [DATA_W-1:0]  rdata;
    logic               false_carrier;
    logic               receive_error;
    line_status_t       status;
    logic [STRAP_W-1:0] strap;
    logic               soft_reset;
    logic               loopback;
    logic [DATA_W-1:0]  phy_ctrl;
    logic [DATA_W-1:0]  pcs_cfg;
    logic [DATA_W-1:0]  slow_link;
    logic [DATA_W-1:0]  line_test;
    logic               irq;
    int                 n_errors    = 0;
    int                 comparisons = 0;
    int                 cycles      = 0;
    int                 cnt;
    row_t               rows [7] = '{
        '{5'h16, 16'hffff, 16'h1f27},
        '{5'h1b, 16'hffff, 16'hff1f},
        '{5'h1a, 16'hffff, 16'h01c3},
        '{5'h17, 16'hffff, 16'h0000},
        '{5'h11, 16'hffff, 16'h0000},
        '{5'h1f, 16'hffff, 16'h0000},
        '{5'h14, 16'hffff, 16'h0000}};

    phy_mgmt_register_bank i_dut (.clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .false_carrier_i(false_carrier),
        .receive_error_i(receive_error), .status_i(status), .strap_i(strap),
        .soft_reset_o(soft_reset), .loopback_o(loopback), .pcs_cfg_o(pcs_cfg),
        .phy_ctrl_o(phy_ctrl), .slow_link_o(slow_link), .line_test_o(line_test), .irq_o(irq));

    line_side_model i_line (.clk_i(clk), .phy_ctrl_i(phy_ctrl), .false_carrier_o(false_carrier),
        .receive_error_o(receive_error), .status_o(status), .strap_o(strap));

    initial begin
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [4:0] a, input logic [15:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk(rdata, exp, what);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            wrap_up();
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        // ----------------------------------------
        // Reset values
        // ----------------------------------------
        rd_reg(5'h00, 16'h0000, "control");
        rd_reg(5'h16, PCS_RESET, "pcs");
        rd_reg(5'h19, 16'h005a, "phy ctrl");
        rd_reg(5'h1a, SLOW_LINK_RESET, "slow link");
        rd_reg(5'h1b, LINE_TEST_RESET, "line test");
        rd_reg(5'h1e, 16'h0001, "latched");
        $display("reset test done");
        // ----------------------------------------
        // Write and read back rows
        // ----------------------------------------
        foreach (rows[i]) begin
            wr_reg(rows[i].ofs, rows[i].wval);
            rd_reg(rows[i].ofs, rows[i].rval, "row");
        end
        chk(pcs_cfg, 16'h1f27, "pcs out");
        chk(slow_link, 16'h01c3, "slow link out");
        chk(line_test, 16'hff1f, "line test out");
        $display("row test done");
        wr_reg(5'h00, 16'h4000);
        #1 chk(16'(loopback), 16'h0001, "loopback on");
        chk(16'(soft_reset), 16'h0000, "no reset");
        rd_reg(5'h00, 16'h4000, "control loop");
        wr_reg(5'h00, 16'h0000);
        #1 chk(16'(loopback), 16'h0000, "loopback off");
        $display("loopback test done");
        // ----------------------------------------
        // Counters and interrupt
        // ----------------------------------------
        i_line.blip(0, 3);
        rd_reg(5'h14, 16'h0003, "false carrier");
        rd_reg(5'h14, 16'h0000, "false cleared");
        chk(16'(irq), 16'h0000, "irq masked");
        wr_reg(IRQ_MASK_OFS, 16'h0001);
        repeat (2) @(posedge clk);
        #1 chk(16'(irq), 16'h0001, "irq raised");
        wr_reg(IRQ_STATUS_OFS, 16'h0001);
        repeat (2) @(posedge clk);
        #1 chk(16'(irq), 16'h0000, "irq cleared");
        i_line.blip(1, 260);
        rd_reg(5'h15, 16'h00ff, "rx error sat");
        rd_reg(5'h15, 16'h0000, "rx cleared");
        $display("counter test done");
        // ----------------------------------------
        // Event bit, self-test, latched bits
        // ----------------------------------------
        i_line.set_line(1'b1, 1'b1);
        repeat (3) @(posedge clk);
        rd_reg(5'h19, 16'h00da, "pause on");
        rd_reg(5'h1a, 16'h01d3, "polarity");
        i_line.set_line(1'b0, 1'b0);
        repeat (3) @(posedge clk);
        rd_reg(5'h19, 16'h005a, "pause off");
        wr_reg(5'h19, 16'h0200);
        rd_reg(5'h19, 16'h0200, "test start");
        repeat (12) @(posedge clk);
        rd_reg(5'h19, 16'h0400, "test result");
        i_line.blip(2, 2);
        rd_reg(5'h1e, 16'h0000, "link latched");
        rd_reg(5'h1e, 16'h0001, "link reload");
        i_line.blip(3, 2);
        rd_reg(5'h1e, 16'h0003, "jabber latched");
        rd_reg(5'h1e, 16'h0001, "jabber reload");
        $display("status test done");
        // ----------------------------------------
        // Software reset
        // ----------------------------------------
        i_line.set_strap(7'h23);
        i_line.blip(1, 2);
        repeat (4) @(posedge clk);
        wr_reg(5'h00, 16'h8000);
        #1 chk(16'(soft_reset), 16'h0001, "reset runs");
        rd_reg(5'h00, 16'h8000, "reset bit");
        cnt = 3;
        while (soft_reset === 1'b1 && cnt < 200) begin
            @(posedge clk);
            #1;
            if (soft_reset === 1'b1) cnt++;
        end
        chk(16'(cnt), 16'(SW_RESET_CYCLES), "reset length");
        rd_reg(5'h00, 16'h0000, "reset done");
        rd_reg(5'h19, 16'h0023, "restrapped");
        rd_reg(5'h1b, LINE_TEST_RESET, "test default");
        rd_reg(5'h15, 16'h0000, "rx reset");
        chk(line_test, LINE_TEST_RESET, "line test out reset");
        chk(pcs_cfg, PCS_RESET, "pcs out reset");
        chk(phy_ctrl, 16'h0023, "phy ctrl out");
        $display("soft reset test done");
        rd_reg(IRQ_STATUS_OFS, 16'h003e, "irq status");
        rd_reg(IRQ_MASK_OFS, 16'h0001, "irq mask");
        chk(16'(irq), 16'h0000, "irq quiet");
        $display("interrupt test done");
        wrap_up();
    end
endmodule
`default_nettype wire
